// [hw/tcm_channel.sv]
// one 16-bit timer channel: mode register, triggers and counting
// assumes prescaled clock ticks and master interrupt share clock_in;
// the timer input pin is asynchronous
`timescale 1ns/1ps
module tcm_channel
	import tcm_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input tcm_pkg::tcm_apb_req_s apb_req_in,
	output tcm_pkg::tcm_apb_rsp_s apb_rsp_out,
	input wire logic [3:0] prescaled_clock_in,
	input wire logic master_irq_in,
	input wire logic timer_input_pin_in,
	output logic timer_out_out,
	output logic irq_pulse_out,
	output logic irq_flag_out,
	output logic running_out
);
	import tcm_pkg::*;

	// the split mode uses the low half, so width must be even and fit
	if (CNT_W < 4 || CNT_W > 16 || (CNT_W % 2) != 0) begin : g_chk
		$error("tcm_channel: CNT_W must be even, 4 to 16");
	end

	tcm_state_s st;
	tcm_state_s next_st;

	// operation clock select, note the swapped middle codes
	function automatic logic op_sel(input logic [3:0] ck,
		input logic [1:0] cks);
		case (cks)
			2'b00: op_sel = ck[0];
			2'b01: op_sel = ck[2];
			2'b10: op_sel = ck[1];
			default: op_sel = ck[3];
		endcase
	endfunction

	// is the mode code one that the channel may run
	function automatic logic mode_ok(input logic [3:0] md);
		case (md[3:1])
			TCM_M_INTERVAL, TCM_M_CAPTURE, TCM_M_ONECOUNT: mode_ok = 1'b1;
			TCM_M_EVENT, TCM_M_CAPONE: mode_ok = ~md[0];
			default: mode_ok = 1'b0;
		endcase
	endfunction

	logic [1:0] f_cks;
	logic f_ccs;
	logic f_split;
	logic [2:0] f_sts;
	logic [1:0] f_cis;
	logic [2:0] f_md;
	logic f_md0;
	logic m_ok;
	logic [15:0] mask;
	logic chg;
	logic rise;
	logic fall;
	logic valid_edge;
	logic start_edge;
	logic op_tick;
	logic cnt_tick;
	logic hw_start;
	logic hw_cap;
	logic acc;
	logic wr;
	logic sw_start;
	logic sw_stop;
	logic start_req;
	logic mapped;
	logic down;

	// mode register fields
	assign f_cks = st.mode[TCM_CKS_LSB +: 2];
	assign f_ccs = st.mode[TCM_CCS_BIT];
	assign f_split = st.mode[TCM_SPLIT_BIT];
	assign f_sts = st.mode[TCM_STS_LSB +: 3];
	assign f_cis = st.mode[TCM_CIS_LSB +: 2];
	assign f_md = st.mode[TCM_MD_LSB +: 3];
	assign f_md0 = st.mode[TCM_MD0_BIT];
	assign m_ok = mode_ok({f_md, f_md0});
	assign down = (f_md == TCM_M_INTERVAL) || (f_md == TCM_M_EVENT) ||
		(f_md == TCM_M_ONECOUNT);
	// split keeps the counter in its low half
	assign mask = f_split ? 16'((1 << (CNT_W / 2)) - 1) :
		16'((1 << CNT_W) - 1);

	// pin change counts once second and third stage agree
	assign chg = (st.sync[1] == st.sync[2]) &&
		(st.sync[2] != st.pin_lvl);
	assign rise = chg & st.sync[2];
	assign fall = chg & ~st.sync[2];
	// valid edge: falling, rising, or both for width measuring
	assign valid_edge = f_cis[1] ? (rise | fall) :
		(f_cis[0] ? rise : fall);
	// start edge of the pair; the capture edge is the other one
	assign start_edge = f_cis[0] ? rise : fall;

	// count clock: prescaled tick or pin edge
	assign op_tick = op_sel(prescaled_clock_in, f_cks);
	assign cnt_tick = f_ccs ? valid_edge : op_tick;

	// hardware start and capture triggers
	always_comb begin
		hw_start = 1'b0;
		hw_cap = 1'b0;
		case (f_sts)
			TCM_T_PIN: begin
				hw_start = valid_edge;
				hw_cap = valid_edge;
			end
			TCM_T_BOTH: begin
				hw_start = start_edge;
				hw_cap = f_cis[0] ? fall : rise;
			end
			TCM_T_MASTER: hw_start = master_irq_in;
			default: begin
				hw_start = 1'b0;
				hw_cap = 1'b0;
			end
		endcase
	end

	// apb decode; zero wait states, so access is the write edge
	assign acc = apb_req_in.psel & apb_req_in.penable;
	assign wr = acc & apb_req_in.pwrite;
	assign sw_start = wr && apb_req_in.paddr == TCM_OFS_CTRL &&
		apb_req_in.pwdata[TCM_CTRL_START_BIT];
	assign sw_stop = wr && apb_req_in.paddr == TCM_OFS_CTRL &&
		apb_req_in.pwdata[TCM_CTRL_STOP_BIT];
	assign mapped = apb_req_in.paddr inside {TCM_OFS_MODE, TCM_OFS_CTRL,
		TCM_OFS_RELOAD, TCM_OFS_COUNT, TCM_OFS_STATUS, TCM_OFS_CAPTURE};
	// in sw-only mode the software start begins counting at once
	assign start_req = m_ok && ((sw_start && f_sts == TCM_T_SW) ||
		(st.enabled && hw_start && f_sts != TCM_T_SW));

	// next state of the whole channel
	always_comb begin
		logic irq_ev;
		logic is_cap;
		irq_ev = 1'b0;
		is_cap = (f_md == TCM_M_CAPTURE) || (f_md == TCM_M_CAPONE);
		next_st = st;
		next_st.sync = {st.sync[1:0], timer_input_pin_in};
		if (chg) begin
			next_st.pin_lvl = st.sync[2];
		end
		// counting
		if (start_req && !st.running) begin
			next_st.running = 1'b1;
			next_st.cnt = down ? st.reload : TCM_CNT_RST;
			if (f_md0 && f_md != TCM_M_ONECOUNT) begin
				irq_ev = 1'b1;
				next_st.tout = ~st.tout;
			end
		end else if (st.running && is_cap && hw_cap) begin
			next_st.cap = st.cnt;
			irq_ev = 1'b1;
			next_st.cnt = TCM_CNT_RST;
			if (f_md == TCM_M_CAPONE) begin
				next_st.running = 1'b0;
			end
		end else if (start_req && f_md == TCM_M_ONECOUNT && f_md0) begin
			next_st.cnt = st.reload;
			irq_ev = 1'b1;
		end else if (st.running && cnt_tick) begin
			// restarts in other modes fall through and are ignored
			case (f_md)
				TCM_M_CAPTURE, TCM_M_CAPONE: begin
					next_st.cnt = st.cnt + 16'h0001;
				end
				default: begin
					if (st.cnt == 16'h0000) begin
						irq_ev = 1'b1;
						if (f_md != TCM_M_EVENT) begin
							next_st.tout = ~st.tout;
						end
						if (f_md == TCM_M_ONECOUNT) begin
							next_st.running = 1'b0;
						end else begin
							next_st.cnt = st.reload;
						end
					end else begin
						next_st.cnt = st.cnt - 16'h0001;
					end
				end
			endcase
		end
		// a prohibited mode halts the count
		if (!m_ok) begin
			next_st.running = 1'b0;
		end
		if (sw_start) begin
			next_st.enabled = 1'b1;
		end
		if (sw_stop) begin
			next_st.enabled = 1'b0;
			next_st.running = 1'b0;
		end
		// register writes
		if (wr && apb_req_in.paddr == TCM_OFS_MODE) begin
			next_st.mode = apb_req_in.pwdata[15:0] & TCM_MODE_WMASK;
		end
		if (wr && apb_req_in.paddr == TCM_OFS_RELOAD) begin
			next_st.reload = apb_req_in.pwdata[15:0];
		end
		if (wr && apb_req_in.paddr == TCM_OFS_STATUS &&
			apb_req_in.pwdata[TCM_ST_IRQ_BIT]) begin
			next_st.irq_flag = 1'b0;
		end
		// set after clear, so a new request is never lost
		if (irq_ev) begin
			next_st.irq_flag = 1'b1;
		end
		next_st.irq_pls = irq_ev;
		next_st.cnt = next_st.cnt & mask;
		// read data sampled in the setup phase, shown in access
		if (apb_req_in.psel && !apb_req_in.penable) begin
			case (apb_req_in.paddr)
				TCM_OFS_MODE: next_st.prdata = {16'h0000, st.mode};
				TCM_OFS_RELOAD: next_st.prdata = {16'h0000, st.reload};
				TCM_OFS_COUNT: next_st.prdata = {16'h0000, st.cnt};
				TCM_OFS_CAPTURE: next_st.prdata = {16'h0000, st.cap};
				TCM_OFS_STATUS: begin
					next_st.prdata = 32'h0000_0000;
					next_st.prdata[TCM_ST_IRQ_BIT] = st.irq_flag;
					next_st.prdata[TCM_ST_RUN_BIT] = st.running;
					next_st.prdata[TCM_ST_TOUT_BIT] = st.tout;
					next_st.prdata[TCM_ST_EN_BIT] = st.enabled;
				end
				default: next_st.prdata = 32'h0000_0000;
			endcase
		end
	end

	// single state register, synchronous reset
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			st <= '0;
			st.mode <= TCM_MODE_RST;
			st.reload <= TCM_RELOAD_RST;
			st.cnt <= TCM_CNT_RST;
		end else begin
			st <= next_st;
		end
	end

	// outputs
	// one driver for the whole response; pready is constant
	assign apb_rsp_out = '{prdata: st.prdata, pready: 1'b1,
		pslverr: acc & ~mapped};
	assign timer_out_out = st.tout;
	assign irq_pulse_out = st.irq_pls;
	assign irq_flag_out = st.irq_flag;
	assign running_out = st.running;

	// checks; quiet cycles have no register write
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	AST_OPCLK_SEL: assert property (
		st.running && !f_ccs && f_cks == 2'b01 && !prescaled_clock_in[2] &&
		f_md == TCM_M_INTERVAL && !wr |=> $stable(st.cnt))
		else $error("count moved without selected clock");
	AST_PIN_CLK: assert property (
		st.running && f_ccs && !chg && f_md == TCM_M_EVENT && !wr
		|=> $stable(st.cnt))
		else $error("pin-clocked count moved without edge");
	AST_SPLIT: assert property (
		f_split |=> st.cnt[CNT_W-1:CNT_W/2] == '0 || !f_split)
		else $error("split counter upper half not zero");
	AST_SW_ONLY: assert property (
		!st.running && f_sts == TCM_T_SW && !sw_start |=> !st.running)
		else $error("sw-only channel started without software");
	AST_PIN_START: assert property (
		st.enabled && !st.running && m_ok && f_sts == TCM_T_PIN &&
		valid_edge && !wr |=> st.running)
		else $error("pin edge did not start channel");
	AST_MASTER: assert property (
		st.enabled && !st.running && m_ok && f_sts == TCM_T_MASTER &&
		master_irq_in && !wr |=> st.running)
		else $error("master interrupt did not start channel");
	AST_DOWN: assert property (
		st.running && f_md == TCM_M_INTERVAL && cnt_tick &&
		st.cnt != 16'h0000 && !wr |=> st.cnt == $past(st.cnt) - 16'h0001)
		else $error("interval mode did not count down");
	AST_UP: assert property (
		st.running && f_md == TCM_M_CAPTURE && cnt_tick && !hw_cap &&
		st.cnt < mask && !wr |=> st.cnt == $past(st.cnt) + 16'h0001)
		else $error("capture mode did not count up");
	AST_START_IRQ: assert property (
		start_req && !st.running && f_md0 && f_md == TCM_M_INTERVAL
		|=> irq_pulse_out && timer_out_out != $past(timer_out_out))
		else $error("start did not raise interrupt and toggle");
	AST_ONE_IGNORE: assert property (
		st.running && f_md == TCM_M_ONECOUNT && !f_md0 && start_req &&
		!cnt_tick && !wr |=> $stable(st.cnt) ##0 !irq_pulse_out)
		else $error("one-count restart not ignored");
	AST_RSVD: assert property (
		st.mode[13] == 1'b0 && st.mode[5:4] == 2'b00)
		else $error("unused mode bits stored");
	AST_STOP: assert property (
		sw_stop |=> !st.running && !st.enabled)
		else $error("stop trigger did not stop");
	AST_FLAG: assert property (
		irq_pulse_out |-> irq_flag_out ##1 (irq_flag_out || $past(wr)))
		else $error("interrupt flag not set with request");
	AST_BOTH_START: assert property (
		st.enabled && !st.running && m_ok && f_sts == TCM_T_BOTH &&
		start_edge && !wr |=> st.running)
		else $error("start edge did not start channel");
	AST_EDGE_SEL: assert property (
		!f_cis[1] && (f_cis[0] ? fall : rise) |-> !valid_edge)
		else $error("wrong pin edge taken as valid");
	AST_EVENT_DOWN: assert property (
		st.running && f_md == TCM_M_EVENT && cnt_tick &&
		st.cnt != 16'h0000 && !wr
		|=> st.cnt == $past(st.cnt) - 16'h0001)
		else $error("event counter did not count down");
	AST_ONE_DOWN: assert property (
		st.running && f_md == TCM_M_ONECOUNT && cnt_tick &&
		!start_req && st.cnt != 16'h0000 && !wr
		|=> st.cnt == $past(st.cnt) - 16'h0001)
		else $error("one-count mode did not count down");
	AST_ONE_RESTART: assert property (
		st.running && f_md == TCM_M_ONECOUNT && f_md0 && start_req &&
		!f_split && !wr |=> irq_pulse_out && st.cnt == $past(st.reload))
		else $error("one-count restart not taken");
	AST_CAPONE_STOP: assert property (
		st.running && f_md == TCM_M_CAPONE && hw_cap
		|=> !st.running && st.cap == $past(st.cnt))
		else $error("capture one-count did not stop on capture");
	AST_CAPONE_QUIET: assert property (
		start_req && !st.running && f_md == TCM_M_CAPONE
		|=> !irq_pulse_out && $stable(timer_out_out))
		else $error("capture one-count start changed output");

	COV_INTERVAL: cover property (
		st.running && f_md == TCM_M_INTERVAL ##1 irq_pulse_out);
	COV_CAPTURE: cover property (
		st.running && f_md == TCM_M_CAPTURE && hw_cap);
	COV_ONE_RESTART: cover property (
		st.running && f_md == TCM_M_ONECOUNT && f_md0 && start_req);
	COV_WIDTH: cover property (
		st.running && f_md == TCM_M_CAPONE && hw_cap);
	COV_EVENT: cover property (
		st.running && f_md == TCM_M_EVENT && cnt_tick);
endmodule

// [common/tcm_pkg.sv]
// shared constants, types and register map of the timer channel block
// assumes one clock domain and an apb master with 32-bit data
package tcm_pkg;
	// register byte offsets
	localparam logic [7:0] TCM_OFS_MODE = 8'h00;
	localparam logic [7:0] TCM_OFS_CTRL = 8'h04;
	localparam logic [7:0] TCM_OFS_RELOAD = 8'h08;
	localparam logic [7:0] TCM_OFS_COUNT = 8'h0c;
	localparam logic [7:0] TCM_OFS_STATUS = 8'h10;
	localparam logic [7:0] TCM_OFS_CAPTURE = 8'h14;
	// mode register field positions
	localparam int TCM_CKS_LSB = 14;
	localparam int TCM_CCS_BIT = 12;
	localparam int TCM_SPLIT_BIT = 11;
	localparam int TCM_STS_LSB = 8;
	localparam int TCM_CIS_LSB = 6;
	localparam int TCM_MD_LSB = 1;
	localparam int TCM_MD0_BIT = 0;
	// bits 13, 5 and 4 never store
	localparam logic [15:0] TCM_MODE_WMASK = 16'hdfcf;
	// control and status bit positions
	localparam int TCM_CTRL_START_BIT = 0;
	localparam int TCM_CTRL_STOP_BIT = 1;
	localparam int TCM_ST_IRQ_BIT = 0;
	localparam int TCM_ST_RUN_BIT = 1;
	localparam int TCM_ST_TOUT_BIT = 2;
	localparam int TCM_ST_EN_BIT = 3;
	// values after reset
	localparam logic [15:0] TCM_MODE_RST = 16'h0000;
	localparam logic [15:0] TCM_RELOAD_RST = 16'h0000;
	localparam logic [15:0] TCM_CNT_RST = 16'h0000;
	localparam int TCM_SYNC_N = 3;

	typedef enum logic [2:0] {
		TCM_M_INTERVAL = 3'b000,
		TCM_M_CAPTURE = 3'b010,
		TCM_M_EVENT = 3'b011,
		TCM_M_ONECOUNT = 3'b100,
		TCM_M_CAPONE = 3'b110
	} tcm_mode_e;

	typedef enum logic [2:0] {
		TCM_T_SW = 3'b000,
		TCM_T_PIN = 3'b001,
		TCM_T_BOTH = 3'b010,
		TCM_T_MASTER = 3'b100
	} tcm_trig_e;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} tcm_apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} tcm_apb_rsp_s;

	typedef struct packed {
		logic [15:0] mode;
		logic [15:0] reload;
		logic [15:0] cnt;
		logic [15:0] cap;
		logic enabled;
		logic running;
		logic irq_flag;
		logic irq_pls;
		logic tout;
		logic [TCM_SYNC_N-1:0] sync;
		logic pin_lvl;
		logic [31:0] prdata;
	} tcm_state_s;
endpackage

// [tb/tcm_pin_model.sv]
// model of the external source on the timer input pin
// assumes the pin is actively driven at all times, never released
`timescale 1ns/1ps
module tcm_pin_model (
	input wire logic clock_in,
	output logic pin_out
);
	initial pin_out = 1'b0;

	// change just after an edge, then hold six clocks
	// so the three-stage synchroniser always sees the level
	task automatic set_level(input logic lvl);
		@(posedge clock_in);
		pin_out <= lvl;
		repeat (6) @(posedge clock_in);
	endtask
endmodule

// [tb/tb_tcm_channel.sv]
// self-checking bench of the timer channel block
// assumes apb offsets of tcm_pkg and the pin model on the input pin
`timescale 1ns/1ps
module tb_tcm_channel;
	import tcm_pkg::*;
	logic clk = 0, rst_n = 0, mirq = 0, last_err;
	logic run, flag, tpin, pls, pl, pin, tout = 0;
	logic [3:0] pck = 0;
	tcm_apb_req_s req = '0;
	tcm_apb_rsp_s rsp;
	logic [31:0] d, r;
	int error_cnt = 0, n_tests = 0;
	integer seed = 32'he28df69b;

	always #2.5 clk = ~clk;

	tcm_channel tcm_channel_inst (.clock_in(clk), .rst_n_in(rst_n),
		.apb_req_in(req), .apb_rsp_out(rsp), .prescaled_clock_in(pck),
		.master_irq_in(mirq), .timer_input_pin_in(pin),
		.timer_out_out(tpin), .irq_pulse_out(pls),
		.irq_flag_out(flag), .running_out(run));
	tcm_pin_model tcm_pin_model_inst (.clock_in(clk), .pin_out(pin));

	task automatic wrap_up();
		if (error_cnt == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] s, e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s exp %h seen %h", nm, e, s);
		end
	endtask

	// one apb transfer; request held until pready is seen, then one
	// idle edge so the next setup never shares a time step with release
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		req <= '{1'b1, 1'b0, w, a, wd};
		@(posedge clk);
		req.penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (rsp.pready !== 1'b1);
		r = rsp.prdata;
		last_err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		// a pulse launched at the access edge is seen here
		@(posedge clk);
		pl = pls;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, r, e);
	endtask

	task automatic tick(input int i, input int n);
		repeat (n) begin
			pck[i] <= 1'b1;
			@(posedge clk);
			pck[i] <= 1'b0;
			@(posedge clk);
		end
	endtask

	task automatic mst();
		mirq <= 1'b1;
		@(posedge clk);
		mirq <= 1'b0;
		@(posedge clk);
		pl = pls;
		repeat (2) @(posedge clk);
	endtask

	// select code to tick index: the two bits swap places
	function automatic int ck_idx(input logic [1:0] c);
		return {c[0], c[1]};
	endfunction

	// hang guard, far above the expected run of some 440 cycles
	initial begin
		#(5 * 20000);
		error_cnt++;
		wrap_up();
	end

	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(TCM_OFS_MODE, 0, "mode rst");
		chk("run rst", run, 0);
		repeat (4) begin
			d = ($random(seed) & 16'hd8c1) | 16'h0004;
			wr(TCM_OFS_MODE, d);
			rd(TCM_OFS_MODE, d, "mode");
		end
		rd(8'h40, 0, "unmapped");
		chk("slverr", last_err, 1);
		// interval mode on every clock select, start bit alternating
		for (int c = 0; c < 4; c++) begin
			d = 16'h0020 + ($random(seed) & 16'h00ff);
			wr(TCM_OFS_MODE, {c[1:0], 13'h0, c[0]});
			wr(TCM_OFS_RELOAD, d);
			wr(TCM_OFS_CTRL, 1);
			chk("start pulse", pl, c[0]);
			tout ^= c[0];
			rd(TCM_OFS_STATUS, {28'h1, tout, 1'b1, c[0]}, "start");
			chk("tout", tpin, tout);
			tick(ck_idx(c[1:0]) ^ 1, 1); // wrong clock must not count
			tick(ck_idx(c[1:0]), 3);
			rd(TCM_OFS_COUNT, d - 3, "count");
			wr(TCM_OFS_CTRL, 2);
			rd(TCM_OFS_STATUS, {29'h0, tout, 1'b0, c[0]}, "stop");
			wr(TCM_OFS_STATUS, 1);
			rd(TCM_OFS_STATUS, {29'h0, tout, 2'b0}, "clear");
		end
		// capture mode: rising edge starts, next rising edge captures
		wr(TCM_OFS_MODE, 16'h0144);
		wr(TCM_OFS_CTRL, 1);
		tcm_pin_model_inst.set_level(1'b1);
		tick(0, 5);
		tcm_pin_model_inst.set_level(1'b0);
		tcm_pin_model_inst.set_level(1'b1);
		rd(TCM_OFS_CAPTURE, 5, "capture");
		chk("cap irq", flag, 1);
		// event counter on falling pin edges
		wr(TCM_OFS_CTRL, 2);
		wr(TCM_OFS_MODE, 16'h1006);
		wr(TCM_OFS_RELOAD, 10);
		wr(TCM_OFS_CTRL, 1);
		repeat (3) begin
			tcm_pin_model_inst.set_level(1'b0);
			tcm_pin_model_inst.set_level(1'b1);
		end
		tick(0, 2); // operation clock is not the count clock here
		rd(TCM_OFS_COUNT, 7, "event");
		// one-count started by the master, retriggered while counting
		for (int m = 0; m < 2; m++) begin
			wr(TCM_OFS_CTRL, 2);
			wr(TCM_OFS_MODE, 16'h0408 | m);
			wr(TCM_OFS_RELOAD, 20);
			wr(TCM_OFS_CTRL, 1);
			mst();
			tick(0, 2);
			rd(TCM_OFS_COUNT, 18, "onecount");
			wr(TCM_OFS_STATUS, 1);
			mst();
			chk("retrig", flag, m);
			chk("retrig pulse", pl, m);
		end
		// width measurement, low then high level
		for (int p = 0; p < 2; p++) begin
			wr(TCM_OFS_CTRL, 2);
			tcm_pin_model_inst.set_level(!p[0]);
			wr(TCM_OFS_MODE, 16'h028c | (p << 6));
			wr(TCM_OFS_STATUS, 1);
			wr(TCM_OFS_CTRL, 1);
			tcm_pin_model_inst.set_level(p[0]);
			chk("c1 irq", flag, 0);
			chk("c1 run", run, 1);
			tick(0, 4);
			tcm_pin_model_inst.set_level(!p[0]);
			rd(TCM_OFS_CAPTURE, 4, "width");
			chk("c1 stop", run, 0);
		end
		// split: counter kept to the low byte
		wr(TCM_OFS_CTRL, 2);
		wr(TCM_OFS_MODE, 16'h0801);
		wr(TCM_OFS_RELOAD, 16'h1234);
		wr(TCM_OFS_CTRL, 1);
		tick(0, 1);
		rd(TCM_OFS_COUNT, 16'h0033, "split");
		wrap_up();
	end
endmodule
